// ==== design/gyro_offset_trim_registers.sv ====
`timescale 1ns/100ps
`default_nettype none

module gyro_offset_trim_registers (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_device_reset,
   input wire gyro_trim_pkg::factory_trim_t i_factory_trim,
   input wire logic [6:0] i_reg_addr,
   input wire logic i_reg_wr_en,
   input wire logic [7:0] i_reg_wr_data,
   input wire logic i_reg_rd_en,
   output logic [7:0] o_reg_rd_data,
   output logic o_reg_rd_valid,
   input wire logic i_raw_valid,
   input wire gyro_trim_pkg::rate_triplet_t i_raw_rate,
   output gyro_trim_pkg::rate_triplet_t o_rate_out,
   output logic o_rate_valid,
   output gyro_trim_pkg::thermal_coef_t o_thermal_coef,
   output logic [2:0] o_tc_active,
   output logic o_active
);

   // Register address match, used by every write strobe and the read mux.
   function automatic logic addr_hit(input logic [6:0] addr, input logic [6:0] target);
      addr_hit = (addr == target);
   endfunction

   logic load_pending_r;
   logic active_r;
   logic do_load;
   logic [2:0][7:0] st_r;
   logic [2:0][9:0] tc_r;
   logic [2:0][15:0] bias_r;
   logic [7:0] rd_data_r;
   logic [7:0] rd_data_nxt;
   logic rd_valid_r;
   logic [2:0] wr_st;
   logic [2:0] wr_tc_high;
   logic [2:0] wr_tc_low;
   logic [2:0] wr_bias_high;
   logic [2:0] wr_bias_low;
   logic [2:0] rate_valid;

   // Trim is loaded on the first edge after reset release and on device reset.
   assign do_load = load_pending_r | i_device_reset;

   // Power-up sequencing: load once, then enter active mode by itself.
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         load_pending_r <= 1'b1;
         active_r <= 1'b0;
      end else begin
         load_pending_r <= 1'b0;
         if (load_pending_r) begin
            active_r <= 1'b1;
         end
      end
   end

   assign o_active = active_r;

   genvar g;
   generate
      // Identical storage for each axis.
      for (g = 0; g < 3; g++) begin : g_axis
         assign wr_st[g] = i_reg_wr_en && addr_hit(i_reg_addr, gyro_trim_pkg::ADDR_ST[g]);
         assign wr_tc_high[g] = i_reg_wr_en
            && addr_hit(i_reg_addr, gyro_trim_pkg::ADDR_TC_HIGH[g]);
         assign wr_tc_low[g] = i_reg_wr_en
            && addr_hit(i_reg_addr, gyro_trim_pkg::ADDR_TC_LOW[g]);
         assign wr_bias_high[g] = i_reg_wr_en
            && addr_hit(i_reg_addr, gyro_trim_pkg::ADDR_BIAS_HIGH[g]);
         assign wr_bias_low[g] = i_reg_wr_en
            && addr_hit(i_reg_addr, gyro_trim_pkg::ADDR_BIAS_LOW[g]);

         // Self-test reference: factory value on load, else software writes.
         always_ff @(posedge i_core_clk or negedge i_nrst) begin
            if (!i_nrst) begin
               st_r[g] <= gyro_trim_pkg::ST_RESET;
            end else if (do_load) begin
               st_r[g] <= i_factory_trim.selftest[g];
            end else if (wr_st[g]) begin
               st_r[g] <= i_reg_wr_data;
            end
         end

         // Compensation pair: load restores factory trim over any software value.
         always_ff @(posedge i_core_clk or negedge i_nrst) begin
            if (!i_nrst) begin
               tc_r[g] <= gyro_trim_pkg::TC_RESET;
            end else if (do_load) begin
               tc_r[g] <= i_factory_trim.thermal[g];
            end else if (wr_tc_high[g]) begin
               tc_r[g][9:8] <= i_reg_wr_data[1:0];
            end else if (wr_tc_low[g]) begin
               tc_r[g][7:0] <= i_reg_wr_data;
            end
         end

         // User bias: cleared on load, written a byte at a time.
         always_ff @(posedge i_core_clk or negedge i_nrst) begin
            if (!i_nrst) begin
               bias_r[g] <= gyro_trim_pkg::BIAS_RESET;
            end else if (do_load) begin
               bias_r[g] <= gyro_trim_pkg::BIAS_RESET;
            end else if (wr_bias_high[g]) begin
               bias_r[g][15:8] <= i_reg_wr_data;
            end else if (wr_bias_low[g]) begin
               bias_r[g][7:0] <= i_reg_wr_data;
            end
         end

         // Coefficient goes out as stored; o_tc_active flags it applied only when nonzero.
         assign o_thermal_coef.coef[g] = tc_r[g];
         assign o_tc_active[g] = (tc_r[g] != gyro_trim_pkg::TC_RESET);

         bias_adder u_bias_adder (
            .i_core_clk(i_core_clk),
            .i_nrst(i_nrst),
            .i_valid(i_raw_valid),
            .i_raw(i_raw_rate.axis[g]),
            .i_bias(bias_r[g]),
            .o_sum(o_rate_out.axis[g]),
            .o_valid(rate_valid[g])
         );
      end
   endgenerate

   assign o_rate_valid = rate_valid[0];

   // Read mux; reserved high bits and unmapped addresses read zero.
   always_comb begin
      rd_data_nxt = gyro_trim_pkg::UNMAPPED_READ;
      for (int i = 0; i < 3; i++) begin
         if (addr_hit(i_reg_addr, gyro_trim_pkg::ADDR_ST[i])) begin
            rd_data_nxt = st_r[i];
         end else if (addr_hit(i_reg_addr, gyro_trim_pkg::ADDR_TC_HIGH[i])) begin
            rd_data_nxt = {6'h00, tc_r[i][9:8]};
         end else if (addr_hit(i_reg_addr, gyro_trim_pkg::ADDR_TC_LOW[i])) begin
            rd_data_nxt = tc_r[i][7:0];
         end else if (addr_hit(i_reg_addr, gyro_trim_pkg::ADDR_BIAS_HIGH[i])) begin
            rd_data_nxt = bias_r[i][15:8];
         end else if (addr_hit(i_reg_addr, gyro_trim_pkg::ADDR_BIAS_LOW[i])) begin
            rd_data_nxt = bias_r[i][7:0];
         end
      end
   end

   // Read data is registered and held until the next read.
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rd_data_r <= gyro_trim_pkg::UNMAPPED_READ;
         rd_valid_r <= 1'b0;
      end else begin
         if (i_reg_rd_en) begin
            rd_data_r <= rd_data_nxt;
         end
         rd_valid_r <= i_reg_rd_en;
      end
   end

   assign o_reg_rd_data = rd_data_r;
   assign o_reg_rd_valid = rd_valid_r;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);

   // Active mode follows the power-up load by exactly one edge.
   active_after_load_a: assert property (load_pending_r |=> o_active)
      else $error("device not active after power-up load");

   // Self-test references take factory values on every load, for all three axes.
   selftest_load_a: assert property (do_load |=> st_r == $past(i_factory_trim.selftest))
      else $error("self-test reference not loaded from trim");

   // Reserved high compensation bits read back zero.
   tc_high_read_a: assert property (
      i_reg_rd_en && addr_hit(i_reg_addr, gyro_trim_pkg::ADDR_TC_HIGH[1])
      |=> o_reg_rd_valid && o_reg_rd_data[7:2] == 6'h00
         && o_reg_rd_data[1:0] == $past(tc_r[1][9:8]))
      else $error("reserved compensation bits not zero");

   // Every compensation pair is restored from trim on load.
   tc_restore_a: assert property (do_load |=> tc_r == $past(i_factory_trim.thermal))
      else $error("compensation pair not restored");

   // Writing zero to both bytes of a pair stops its compensation.
   tc_zero_write_a: assert property (
      !do_load && i_reg_wr_data == 8'h00
      && ((wr_tc_low[2] && tc_r[2][9:8] == 2'b00)
         || (wr_tc_high[2] && tc_r[2][7:0] == 8'h00))
      |=> !o_tc_active[2])
      else $error("zero write did not stop compensation");

   // Low byte writes land in coefficient bits 7:0 only.
   tc_low_write_a: assert property (
      !do_load && wr_tc_low[0]
      |=> tc_r[0][7:0] == $past(i_reg_wr_data) && tc_r[0][9:8] == $past(tc_r[0][9:8]))
      else $error("low compensation byte write wrong");

   // User bias is zero after every load.
   bias_clear_a: assert property (do_load |=> bias_r == '0)
      else $error("user bias not cleared on load");

   // Output word is raw plus bias with 16-bit wrap, one edge after the sample.
   rate_sum_a: assert property (
      i_raw_valid |=> o_rate_valid
         && o_rate_out.axis[1] == 16'($past(i_raw_rate.axis[1]) + $past(bias_r[1])))
      else $error("rate output not raw plus bias");

   // Exported coefficient matches the two register bytes.
   coef_export_a: assert property (
      o_thermal_coef.coef[0] == {tc_r[0][9:8], tc_r[0][7:0]}
      && o_tc_active[0] == (tc_r[0] != 10'h000))
      else $error("exported coefficient wrong");

   // Reference writes land whole when no load competes.
   st_write_a: assert property (
      !do_load && wr_st[0]
      |=> st_r[0] == $past(i_reg_wr_data))
      else $error("self-test reference write lost");

   // A read of a reference returns the stored byte.
   st_read_a: assert property (
      i_reg_rd_en && addr_hit(i_reg_addr, gyro_trim_pkg::ADDR_ST[2])
      |=> o_reg_rd_data == $past(st_r[2]))
      else $error("self-test reference read wrong");

   // High byte writes reach coefficient bits 9:8 only.
   tc_high_write_a: assert property (
      !do_load && wr_tc_high[1]
      |=> tc_r[1][9:8] == $past(i_reg_wr_data[1:0])
         && tc_r[1][7:0] == $past(tc_r[1][7:0]))
      else $error("high compensation byte write wrong");

   // Reserved bits of the Z high byte read zero as well.
   tc_high_z_read_a: assert property (
      i_reg_rd_en && addr_hit(i_reg_addr, gyro_trim_pkg::ADDR_TC_HIGH[2])
      |=> o_reg_rd_data[7:2] == 6'h00)
      else $error("reserved Z compensation bits not zero");

   // A low byte read matches the exported coefficient.
   coef_read_a: assert property (
      i_reg_rd_en && addr_hit(i_reg_addr, gyro_trim_pkg::ADDR_TC_LOW[1])
      |=> o_reg_rd_data == $past(o_thermal_coef.coef[1][7:0]))
      else $error("low compensation byte read wrong");

   // Bias high bytes land in bits 15:8 and leave the low byte alone.
   bias_high_write_a: assert property (
      !do_load && wr_bias_high[2]
      |=> bias_r[2][15:8] == $past(i_reg_wr_data)
         && bias_r[2][7:0] == $past(bias_r[2][7:0]))
      else $error("bias high byte write wrong");

   // Bias low bytes land in bits 7:0 and leave the high byte alone.
   bias_low_write_a: assert property (
      !do_load && wr_bias_low[0]
      |=> bias_r[0][7:0] == $past(i_reg_wr_data)
         && bias_r[0][15:8] == $past(bias_r[0][15:8]))
      else $error("bias low byte write wrong");

   // A bias byte read returns the stored byte.
   bias_read_a: assert property (
      i_reg_rd_en && addr_hit(i_reg_addr, gyro_trim_pkg::ADDR_BIAS_HIGH[1])
      |=> o_reg_rd_data == $past(bias_r[1][15:8]))
      else $error("bias byte read wrong");

   // Indices above the bank read back zero.
   unmapped_read_a: assert property (
      i_reg_rd_en && i_reg_addr > gyro_trim_pkg::ADDR_BIAS_LOW[2]
      |=> o_reg_rd_data == gyro_trim_pkg::UNMAPPED_READ)
      else $error("unmapped read not zero");

   // Read valid follows a taken read by exactly one edge.
   rd_valid_a: assert property (
      i_reg_rd_en |=> o_reg_rd_valid)
      else $error("read valid missing");

   // Read valid never appears without a read.
   rd_valid_idle_a: assert property (
      !i_reg_rd_en |=> !o_reg_rd_valid)
      else $error("read valid without a read");

   // Read data holds between reads.
   rd_hold_a: assert property (
      !i_reg_rd_en |=> $stable(o_reg_rd_data))
      else $error("read data changed without a read");

   // Every axis presents its sum on the same edge.
   rate_valid_a: assert property (
      i_raw_valid |=> o_rate_valid && rate_valid == 3'b111)
      else $error("rate valid missing");

   // Without a sample the output neither pulses nor moves.
   rate_idle_a: assert property (
      !i_raw_valid |=> !o_rate_valid && rate_valid == 3'b000 && $stable(o_rate_out))
      else $error("rate output moved without a sample");

   // X axis sum wraps at 16 bits.
   rate_sum_x_a: assert property (
      i_raw_valid
      |=> o_rate_out.axis[0] == 16'($past(i_raw_rate.axis[0]) + $past(bias_r[0])))
      else $error("X rate output not raw plus bias");

   // Z axis sum behaves as X and Y do.
   rate_sum_z_a: assert property (
      i_raw_valid
      |=> o_rate_out.axis[2] == 16'($past(i_raw_rate.axis[2]) + $past(bias_r[2])))
      else $error("Z rate output not raw plus bias");

   // Active mode never drops once reached, device reset included.
   active_hold_a: assert property (
      o_active |=> o_active)
      else $error("device left active mode");

   // Main scenarios.
   cover_sw_zero_c: cover property (active_r && o_tc_active[0] ##[1:20] !o_tc_active[0]);
   cover_dev_reset_c: cover property (active_r && i_device_reset);
   cover_bias_sum_c: cover property (i_raw_valid && bias_r[0] != '0);
   cover_read_c: cover property (o_reg_rd_valid && o_reg_rd_data != 8'h00);
   cover_restore_c: cover property (i_device_reset && o_tc_active != 3'b111
      ##1 o_tc_active == 3'b111);

endmodule

`default_nettype wire

// ==== design/gyro_trim_pkg.sv ====
package gyro_trim_pkg;

   // Register index width of the serial register port.
   localparam int ADDR_W = 7;

   // Self-test reference registers, one per axis, index 0 is X.
   localparam logic [2:0][6:0] ADDR_ST = {7'h02, 7'h01, 7'h00};

   // Thermal compensation pairs, high and low byte per axis.
   localparam logic [2:0][6:0] ADDR_TC_HIGH = {7'h0A, 7'h07, 7'h04};
   localparam logic [2:0][6:0] ADDR_TC_LOW = {7'h0B, 7'h08, 7'h05};

   // User bias pairs, high and low byte per axis.
   localparam logic [2:0][6:0] ADDR_BIAS_HIGH = {7'h17, 7'h15, 7'h13};
   localparam logic [2:0][6:0] ADDR_BIAS_LOW = {7'h18, 7'h16, 7'h14};

   // Field layout of the high compensation byte.
   localparam int TC_HIGH_LSB = 0;
   localparam int TC_HIGH_W = 2;
   localparam int TC_W = 10;

   // Reset values.
   localparam logic [7:0] ST_RESET = 8'h00;
   localparam logic [9:0] TC_RESET = 10'h000;
   localparam logic [15:0] BIAS_RESET = 16'h0000;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Factory trim delivered by the one-time memory.
   typedef struct packed {
      logic [2:0][7:0] selftest;
      logic [2:0][9:0] thermal;
   } factory_trim_t;

   // One 16-bit rate word per axis, index 0 is X.
   typedef struct packed {
      logic [2:0][15:0] axis;
   } rate_triplet_t;

   // Signed compensation coefficients per axis.
   typedef struct packed {
      logic [2:0][9:0] coef;
   } thermal_coef_t;

endpackage

// ==== design/bias_adder.sv ====
`timescale 1ns/100ps
`default_nettype none

module bias_adder (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_valid,
   input wire logic [15:0] i_raw,
   input wire logic [15:0] i_bias,
   output logic [15:0] o_sum,
   output logic o_valid
);

   logic [15:0] sum_r;
   logic [15:0] sum_nxt;
   logic valid_r;

   // Wrapping two's-complement sum of the sample and the user bias.
   assign sum_nxt = 16'($signed(i_raw) + $signed(i_bias));

   // Output word is registered and held until the next sample.
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sum_r <= 16'h0000;
         valid_r <= 1'b0;
      end else begin
         if (i_valid) begin
            sum_r <= sum_nxt;
         end
         valid_r <= i_valid;
      end
   end

   assign o_sum = sum_r;
   assign o_valid = valid_r;

endmodule

`default_nettype wire

// ==== verification/test_gyro_offset_trim_registers.sv ====
`timescale 1ns/100ps
`default_nettype none

module test_gyro_offset_trim_registers;
   logic clk, nrst, dev_rst, wr_en, rd_en, raw_valid, rate_valid, rd_valid, active;
   logic [6:0] addr;
   logic [7:0] wr_data, rd_data;
   logic [2:0] tc_active;
   logic [31:0] seed = 32'h15F8;
   logic [15:0] bias [3];
   logic [47:0] rd_q[$], rate_q[$];
   int fails = 0, n_tests = 0;
   gyro_trim_pkg::factory_trim_t trim;
   gyro_trim_pkg::rate_triplet_t raw_rate, rate_out, exp_rate;
   gyro_trim_pkg::thermal_coef_t coef;

   gyro_offset_trim_registers dut (.i_core_clk(clk), .i_nrst(nrst), .i_device_reset(dev_rst),
      .i_factory_trim(trim), .i_reg_addr(addr), .i_reg_wr_en(wr_en), .i_reg_wr_data(wr_data),
      .i_reg_rd_en(rd_en), .o_reg_rd_data(rd_data), .o_reg_rd_valid(rd_valid),
      .i_raw_valid(raw_valid), .i_raw_rate(raw_rate), .o_rate_out(rate_out),
      .o_rate_valid(rate_valid), .o_thermal_coef(coef), .o_tc_active(tc_active),
      .o_active(active));

   // The 200 MHz core clock.
   always #2.5 clk = ~clk;

   // Xorshift source so that every run sees the same stimulus.
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input logic [47:0] s, input logic [47:0] e);
      n_tests++;
      if (s !== e) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic end_sim();
      $display("comparisons=%0d mismatches=%0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   // A read notes its expected byte before the strobe is taken.
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      rd_q.push_back({40'h0, e});
      @(posedge clk);
      rd_en <= 1'b0;
   endtask

   // Every register must hold its factory or cleared value after a load.
   task automatic check_loaded();
      for (int i = 0; i < 3; i++) begin
         rd(gyro_trim_pkg::ADDR_ST[i], trim.selftest[i]);
         rd(gyro_trim_pkg::ADDR_TC_HIGH[i], {6'h00, trim.thermal[i][9:8]});
         rd(gyro_trim_pkg::ADDR_TC_LOW[i], trim.thermal[i][7:0]);
         rd(gyro_trim_pkg::ADDR_BIAS_HIGH[i], 8'h00);
         rd(gyro_trim_pkg::ADDR_BIAS_LOW[i], 8'h00);
         bias[i] = 16'h0000;
      end
      @(negedge clk);
      chk({18'h0, coef}, {18'h0, trim.thermal});
      chk({45'h0, tc_active}, 48'h7);
   endtask

   // Back-to-back samples; the expected sum wraps at 16 bits.
   task automatic samples(input int n, input logic [15:0] x0);
      for (int k = 0; k < n; k++) begin
         @(posedge clk);
         for (int i = 0; i < 3; i++) begin
            raw_rate.axis[i] <= (k == 0 && i == 0) ? x0 : 16'(rnd());
         end
         raw_valid <= 1'b1;
         #1;
         for (int i = 0; i < 3; i++) begin
            exp_rate.axis[i] = raw_rate.axis[i] + bias[i];
         end
         rate_q.push_back(exp_rate);
      end
      @(posedge clk);
      raw_valid <= 1'b0;
   endtask

   // Monitor: each answer takes the oldest noted expectation.
   always @(negedge clk) begin
      if (rd_valid === 1'b1)
         chk({40'h0, rd_data}, rd_q.size() ? rd_q.pop_front() : 48'hX);
      if (rate_valid === 1'b1)
         chk(rate_out, rate_q.size() ? rate_q.pop_front() : 48'hX);
   end

   // Watchdog: the sequence needs well under a thousand cycles.
   initial begin
      #20000;
      fails++;
      end_sim();
   end

   initial begin
      logic [7:0] v;
      int code;
      real base, resp;
      clk = 0; nrst = 0; dev_rst = 0; addr = '0; wr_en = 0; wr_data = '0;
      rd_en = 0; raw_valid = 0; raw_rate = '0;
      for (int i = 0; i < 3; i++) begin
         trim.selftest[i] = 8'(rnd());
         trim.thermal[i] = 10'(rnd()) | 10'h001;
      end
      repeat (3) @(posedge clk);
      chk({47'h0, active}, 48'h0);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk({47'h0, active}, 48'h1);
      check_loaded();
      for (int i = 0; i < 3; i++) begin
         code = 1 + int'(rnd() % 200);
         base = 2620.0 / (2.0 ** (rnd() % 4));
         resp = base * (1.01 ** (code - 1));
         v = 8'($rtoi($ln(resp / base) / $ln(1.01) + 0.5) + 1);
         wr(gyro_trim_pkg::ADDR_ST[i], v);
         rd(gyro_trim_pkg::ADDR_ST[i], 8'(code));
         wr(gyro_trim_pkg::ADDR_TC_HIGH[i], 8'hFF);
         wr(gyro_trim_pkg::ADDR_TC_LOW[i], 8'h00);
         rd(gyro_trim_pkg::ADDR_TC_HIGH[i], 8'h03);
         @(negedge clk);
         chk({38'h0, coef.coef[i]}, 48'h300);
         wr(gyro_trim_pkg::ADDR_TC_HIGH[i], 8'h00);
         @(negedge clk);
         chk({38'h0, coef.coef[i]}, 48'h0);
         chk({47'h0, tc_active[i]}, 48'h0);
      end
      wr(7'h03, 8'hAA);
      rd(7'h03, 8'h00);
      rd(7'h7F, 8'h00);
      for (int i = 0; i < 3; i++) begin
         bias[i] = (i == 0) ? 16'h0001 : 16'(rnd());
         wr(gyro_trim_pkg::ADDR_BIAS_HIGH[i], bias[i][15:8]);
         wr(gyro_trim_pkg::ADDR_BIAS_LOW[i], bias[i][7:0]);
         rd(gyro_trim_pkg::ADDR_BIAS_HIGH[i], bias[i][15:8]);
         rd(gyro_trim_pkg::ADDR_BIAS_LOW[i], bias[i][7:0]);
      end
      samples(6, 16'h7FFF);
      @(posedge clk);
      dev_rst <= 1'b1;
      @(posedge clk);
      dev_rst <= 1'b0;
      check_loaded();
      samples(2, 16'h8000);
      repeat (3) @(posedge clk);
      chk(48'(rd_q.size() + rate_q.size()), 48'h0);
      end_sim();
   end
endmodule

`default_nettype wire
